/* File: hw/pfdc_cfg.svh */
// Purpose : register map, field positions and reset values of the feedback divider control
// Assumes : byte-wide register access port, one register per address
// Notes   : definitions only
// Summary of operation
// [R1] Control bit 4 set holds the reference, swallow and main counters in reset.
// [R2] The main-counter bypass acts only in fixed-divide prescaler modes.
// [R3] With bypass set the main counter divides by one, so the prescaler alone sets the ratio.
// [R4] Prescaler codes 000, 001 and 111 give fixed divide by 1, 2 and 3.
// [R5] Codes 010 to 110 give P/P+1 with P of 2 to 32, and plain P while the swallow count is 0.
// [R6] Status select bits 7:2 give ground for 000000, swallow output 000011, prescaler 000100.
// [R7] Status select 000001 routes the delayed feedback divider output to the status pin.
// [R8] Status select 000010 routes the delayed reference divider output to the status pin.
// [R9] Swallow count is a six-bit register, main count thirteen bits in low byte and high five.
// [R10] Control bit 6 resets only the reference divider, bit 5 only the prescaler, swallow and main counters.
// [R11] In dual-modulus operation the feedback ratio is P times main count plus swallow count.
`ifndef PFDC_CFG_SVH
`define PFDC_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PFDC_ADDR_REF_LO   8'h11
`define PFDC_ADDR_REF_HI   8'h12
`define PFDC_ADDR_SWALLOW  8'h13
`define PFDC_ADDR_MAIN_LO  8'h14
`define PFDC_ADDR_MAIN_HI  8'h15
`define PFDC_ADDR_CTRL     8'h16
`define PFDC_ADDR_STATUS   8'h17

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PFDC_CTRL_RST_REF  6
`define PFDC_CTRL_RST_AB   5
`define PFDC_CTRL_RST_ALL  4
`define PFDC_CTRL_BYPASS   3
`define PFDC_STAT_SEL_HI   7
`define PFDC_STAT_SEL_LO   2
`define PFDC_REG_RESET     8'h00
`define PFDC_DLY_STAGES    2

`endif

/* File: hw/pfdc_pkg.sv */
// Purpose : types shared by the feedback divider control
// Assumes : nothing
// Notes   : encodings follow the register fields
package pfdc_pkg;
    // prescaler field codes
    typedef enum logic [2:0] {
        PFDC_FD_DIV1  = 3'h0,
        PFDC_FD_DIV2  = 3'h1,
        PFDC_DM_DIV2  = 3'h2,
        PFDC_DM_DIV4  = 3'h3,
        PFDC_DM_DIV8  = 3'h4,
        PFDC_DM_DIV16 = 3'h5,
        PFDC_DM_DIV32 = 3'h6,
        PFDC_FD_DIV3  = 3'h7
    } pfdc_presc_e;

    // status pin selections handled here
    typedef enum logic [5:0] {
        PFDC_SEL_GROUND   = 6'h00,
        PFDC_SEL_FEEDBACK = 6'h01,
        PFDC_SEL_REFDIV   = 6'h02,
        PFDC_SEL_SWALLOW  = 6'h03,
        PFDC_SEL_PRESC    = 6'h04
    } pfdc_stsel_e;
endpackage : pfdc_pkg

/* File: hw/pfdc_div.sv */
// Purpose : programmable divide-by-N counter with tick and toggling outputs
// Assumes : i_div of 0 behaves as 1
// Notes   : tick is combinational, toggle comes from a flop
`timescale 1ns/100ps
module pfdc_div #(
    parameter int W = 14
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clr,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_div,
    output logic              o_tick,
    output logic              o_tog
);
    import pfdc_pkg::*;

    logic [W-1:0] cnt_r;
    logic         tog_r;

    // ----------------------------------------------------------------
    // terminal count decode
    // ----------------------------------------------------------------
    wire [W-1:0] last_cnt = (i_div == '0) ? '0 : i_div - {{(W-1){1'b0}}, 1'b1};
    wire         wrap     = (cnt_r >= last_cnt);
    assign o_tick = i_en && !i_clr && wrap;
    assign o_tog  = tog_r;

    // counter, held at zero while cleared
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (i_clr || (i_en && wrap)) begin
            cnt_r <= '0;
        end else if (i_en) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // toggling output for the status pin
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_r <= 1'b0;
        end else if (i_clr) begin
            tog_r <= 1'b0;
        end else if (o_tick) begin
            tog_r <= ~tog_r;
        end
    end
endmodule : pfdc_div

/* File: hw/pfdc_ctrl.sv */
// Purpose : feedback divider, reference divider and status pin selector control
// Assumes : i_clk is the prescaler input clock; i_ref_tick marks reference edges
// Notes   : registers are written and read through a byte-wide access port
`timescale 1ns/100ps
`include "pfdc_cfg.svh"
module pfdc_ctrl #(
    parameter int DLY = `PFDC_DLY_STAGES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    input  wire logic       i_ref_tick,
    output logic            o_fb_pulse,
    output logic            o_ref_pulse,
    output logic            o_status,
    output pfdc_pkg::pfdc_presc_e o_presc_code
);
    import pfdc_pkg::*;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] ref_lo_r, ref_hi_r, swallow_r, main_lo_r, main_hi_r, ctrl_r, stat_r;
    logic [7:0] rdata_nxt;

    wire wr_ref_lo  = i_wr && (i_addr == `PFDC_ADDR_REF_LO);
    wire wr_ref_hi  = i_wr && (i_addr == `PFDC_ADDR_REF_HI);
    wire wr_swallow = i_wr && (i_addr == `PFDC_ADDR_SWALLOW);
    wire wr_main_lo = i_wr && (i_addr == `PFDC_ADDR_MAIN_LO);
    wire wr_main_hi = i_wr && (i_addr == `PFDC_ADDR_MAIN_HI);
    wire wr_ctrl    = i_wr && (i_addr == `PFDC_ADDR_CTRL);
    wire wr_stat    = i_wr && (i_addr == `PFDC_ADDR_STATUS);

    // register writes; narrow fields keep only their bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_lo_r  <= `PFDC_REG_RESET;
            ref_hi_r  <= `PFDC_REG_RESET;
            swallow_r <= `PFDC_REG_RESET;
            main_lo_r <= `PFDC_REG_RESET;
            main_hi_r <= `PFDC_REG_RESET;
            ctrl_r    <= `PFDC_REG_RESET;
            stat_r    <= `PFDC_REG_RESET;
        end else begin
            if (wr_ref_lo)  ref_lo_r  <= i_wdata;
            if (wr_ref_hi)  ref_hi_r  <= {2'h0, i_wdata[5:0]};
            if (wr_swallow) swallow_r <= {2'h0, i_wdata[5:0]}; // R9
            if (wr_main_lo) main_lo_r <= i_wdata;              // R9
            if (wr_main_hi) main_hi_r <= {3'h0, i_wdata[4:0]}; // R9
            if (wr_ctrl)    ctrl_r    <= i_wdata;
            if (wr_stat)    stat_r    <= {i_wdata[7:2], 2'h0};
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        unique case (i_addr)
            `PFDC_ADDR_REF_LO:  rdata_nxt = ref_lo_r;
            `PFDC_ADDR_REF_HI:  rdata_nxt = ref_hi_r;
            `PFDC_ADDR_SWALLOW: rdata_nxt = swallow_r;
            `PFDC_ADDR_MAIN_LO: rdata_nxt = main_lo_r;
            `PFDC_ADDR_MAIN_HI: rdata_nxt = main_hi_r;
            `PFDC_ADDR_CTRL:    rdata_nxt = ctrl_r;
            `PFDC_ADDR_STATUS:  rdata_nxt = stat_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) o_rdata <= 8'h00;
        else       o_rdata <= rdata_nxt;
    end

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    wire [13:0]   r_val   = {ref_hi_r[5:0], ref_lo_r};
    wire [5:0]    a_val   = swallow_r[5:0];
    wire [12:0]   b_val   = {main_hi_r[4:0], main_lo_r};
    wire          rst_all = ctrl_r[`PFDC_CTRL_RST_ALL];
    wire          clr_ref = ctrl_r[`PFDC_CTRL_RST_REF] || rst_all; // R1 R10
    wire          clr_ab  = ctrl_r[`PFDC_CTRL_RST_AB] || rst_all;  // R1 R10
    wire [5:0]    sel     = stat_r[`PFDC_STAT_SEL_HI:`PFDC_STAT_SEL_LO];
    pfdc_presc_e  p_code;
    assign p_code       = pfdc_presc_e'(ctrl_r[2:0]);
    assign o_presc_code = p_code;

    // prescaler base ratio and mode
    logic [5:0] p_base;
    logic       fixed_divide_mode;
    always_comb begin
        fixed_divide_mode = 1'b0;
        unique case (p_code)
            PFDC_FD_DIV1:  begin p_base = 6'h01; fixed_divide_mode = 1'b1; end // R4
            PFDC_FD_DIV2:  begin p_base = 6'h02; fixed_divide_mode = 1'b1; end // R4
            PFDC_FD_DIV3:  begin p_base = 6'h03; fixed_divide_mode = 1'b1; end // R4
            PFDC_DM_DIV2:  p_base = 6'h02; // R5
            PFDC_DM_DIV4:  p_base = 6'h04; // R5
            PFDC_DM_DIV8:  p_base = 6'h08; // R5
            PFDC_DM_DIV16: p_base = 6'h10; // R5
            PFDC_DM_DIV32: p_base = 6'h20; // R5
        endcase
    end
    wire dual_modulus_mode = !fixed_divide_mode;

    // ----------------------------------------------------------------
    // swallow counter and prescaler modulus
    // ----------------------------------------------------------------
    logic [5:0] a_cnt_r;
    logic       sw_tog_r;
    logic       presc_tick, presc_tog, fb_tick, fb_tog, ref_tick, ref_tog;

    wire       a_done  = (a_cnt_r >= a_val);
    // P+1 for the first A prescaler periods of each main period, then P
    wire       use_p1  = dual_modulus_mode && !a_done;                  // R5 R11
    wire [5:0] modulus = use_p1 ? p_base + 6'h01 : p_base;              // R5 R11
    // bypass only counts in fixed-divide modes
    wire       bypass  = ctrl_r[`PFDC_CTRL_BYPASS] && fixed_divide_mode; // R2
    wire [12:0] main_div = bypass ? 13'h0001 : b_val;                   // R3

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            a_cnt_r <= 6'h00;
        end else if (clr_ab || fb_tick) begin
            a_cnt_r <= 6'h00; // R10
        end else if (presc_tick && !a_done) begin
            a_cnt_r <= a_cnt_r + 6'h01;
        end
    end

    // swallow output toggles when the swallow count completes in a dual-modulus mode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_tog_r <= 1'b0;
        end else if (clr_ab) begin
            sw_tog_r <= 1'b0;
        end else if (presc_tick && dual_modulus_mode && (a_cnt_r + 6'h01 == a_val)) begin
            sw_tog_r <= ~sw_tog_r;
        end
    end

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    pfdc_div #(.W(6)) u_presc (
        .i_clk(i_clk), .i_rst(i_rst), .i_clr(clr_ab), .i_en(1'b1),
        .i_div(modulus), .o_tick(presc_tick), .o_tog(presc_tog)
    );
    pfdc_div #(.W(13)) u_main (
        .i_clk(i_clk), .i_rst(i_rst), .i_clr(clr_ab), .i_en(presc_tick),
        .i_div(main_div), .o_tick(fb_tick), .o_tog(fb_tog)
    );
    pfdc_div #(.W(14)) u_ref (
        .i_clk(i_clk), .i_rst(i_rst), .i_clr(clr_ref), .i_en(i_ref_tick),
        .i_div(r_val), .o_tick(ref_tick), .o_tog(ref_tog)
    );
    assign o_fb_pulse  = fb_tick;
    assign o_ref_pulse = ref_tick;

    // ----------------------------------------------------------------
    // output delay lines and status selector
    // ----------------------------------------------------------------
    logic [DLY-1:0] fb_dly_r, ref_dly_r;
    logic           status_nxt;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fb_dly_r  <= '0;
            ref_dly_r <= '0;
        end else begin
            fb_dly_r  <= {fb_dly_r[DLY-2:0], fb_tog};
            ref_dly_r <= {ref_dly_r[DLY-2:0], ref_tog};
        end
    end

    // ground for the static and unhandled codes
    always_comb begin
        unique case (sel)
            PFDC_SEL_FEEDBACK: status_nxt = fb_dly_r[DLY-1];  // R7
            PFDC_SEL_REFDIV:   status_nxt = ref_dly_r[DLY-1]; // R8
            PFDC_SEL_SWALLOW:  status_nxt = sw_tog_r;         // R6
            PFDC_SEL_PRESC:    status_nxt = presc_tog;        // R6
            default:           status_nxt = 1'b0;             // R6
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) o_status <= 1'b0;
        else       o_status <= status_nxt;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    reset_all_a: assert property (rst_all |-> !fb_tick && !ref_tick && !presc_tick) // R1
        else $error("counter ticked under reset-all");
    ref_reset_a: assert property (ctrl_r[`PFDC_CTRL_RST_REF] |-> !ref_tick) // R10
        else $error("reference divider ticked under its reset");
    // swallow count clears on the edge after the reset bit lands, not at once
    ab_reset_a: assert property (ctrl_r[`PFDC_CTRL_RST_AB] |-> (!presc_tick && !fb_tick) // R10
                                 ##1 (a_cnt_r == 6'h00))
        else $error("swallow or main counter active under reset");
    bypass_dm_a: assert property (!fixed_divide_mode |-> main_div == b_val) // R2
        else $error("bypass took effect in dual-modulus mode");
    bypass_div_a: assert property (fixed_divide_mode && ctrl_r[`PFDC_CTRL_BYPASS] && presc_tick
                                   |-> fb_tick) // R3
        else $error("bypassed main counter did not divide by one");
    fd_ratio_a: assert property (p_code == PFDC_FD_DIV3 |-> modulus == 6'h03) // R4
        else $error("fixed divide by three wrong");
    dm_zero_a: assert property (dual_modulus_mode && a_val == 6'h00 |-> modulus == p_base) // R5
        else $error("swallow zero did not give plain P");
    dm_swallow_a: assert property (dual_modulus_mode && a_cnt_r < a_val
                                   |-> modulus == p_base + 6'h01) // R11
        else $error("swallow period did not use P+1");
    stat_gnd_a: assert property (sel == PFDC_SEL_GROUND |=> !o_status) // R6
        else $error("ground selection not low");
    stat_fb_a: assert property (sel == PFDC_SEL_FEEDBACK |=> o_status == $past(fb_dly_r[DLY-1])) // R7
        else $error("feedback selection mismatch");
    stat_ref_a: assert property (sel == PFDC_SEL_REFDIV |=> o_status == $past(ref_dly_r[DLY-1])) // R8
        else $error("reference selection mismatch");
    swallow_wr_a: assert property (wr_swallow |=> a_val == $past(i_wdata[5:0])) // R9
        else $error("swallow count write lost");

    fb_cov_c:   cover property (dual_modulus_mode && a_val != 6'h00 && fb_tick);
    byp_cov_c:  cover property (bypass && fb_tick);
    ref_cov_c:  cover property (sel == PFDC_SEL_REFDIV && $rose(o_status));
    pres_cov_c: cover property (sel == PFDC_SEL_PRESC && $fell(o_status));
endmodule : pfdc_ctrl

/* File: dv/pfdc_ctrl_test.sv */
// Purpose : self-checking bench for the feedback divider control block
// Assumes : reference ticks come every third clock, reset included
// Notes   : periods are measured between the 2nd and 3rd event seen
`timescale 1ns/100ps
`include "pfdc_cfg.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module pfdc_ctrl_test;
    import pfdc_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} pfdc_tb_reg_s;
    typedef struct {logic [7:0] c; logic [7:0] a; logic [7:0] b; logic [5:0] s;
                    int k; int p;} pfdc_tb_per_s;
    logic        i_clk      = 1'b0;
    logic        i_rst      = 1'b1;
    logic        i_wr       = 1'b0;
    logic [7:0]  i_addr     = 8'h00;
    logic [7:0]  i_wdata    = 8'h00;
    logic        i_ref_tick = 1'b0;
    logic [7:0]  o_rdata;
    logic        o_fb_pulse, o_ref_pulse, o_status;
    pfdc_presc_e o_presc_code;
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          ref_cnt    = 0;
    logic [7:0]  d;
    int          n;
    // readback rows: address, written byte, expected read
    pfdc_tb_reg_s regs [8] = '{'{8'h11, 8'hFF, 8'hFF}, '{8'h12, 8'hFF, 8'h3F},
        '{8'h13, 8'hFF, 8'h3F}, '{8'h14, 8'hFF, 8'hFF}, '{8'h15, 8'hFF, 8'h1F},
        '{8'h17, 8'hFF, 8'hFC}, '{8'h16, 8'hA5, 8'hA5}, '{8'h20, 8'hFF, 8'h00}};
    // period rows: ctrl, swallow, main, status select, watched kind, period
    pfdc_tb_per_s per [19] = '{
        '{8'h01, 8'h00, 8'h01, 6'h00, 0, 2},  '{8'h00, 8'h00, 8'h01, 6'h00, 0, 1},
        '{8'h07, 8'h00, 8'h02, 6'h00, 0, 6},  '{8'h0F, 8'h00, 8'h02, 6'h00, 0, 3},
        '{8'h03, 8'h02, 8'h03, 6'h00, 0, 14}, '{8'h03, 8'h00, 8'h03, 6'h00, 0, 12},
        '{8'h0B, 8'h02, 8'h03, 6'h00, 0, 14}, '{8'h02, 8'h01, 8'h04, 6'h00, 0, 9},
        '{8'h04, 8'h01, 8'h02, 6'h00, 0, 17}, '{8'h05, 8'h00, 8'h01, 6'h00, 0, 16},
        '{8'h06, 8'h01, 8'h02, 6'h00, 0, 65}, '{8'h01, 8'h00, 8'h01, 6'h01, 2, 2},
        '{8'h01, 8'h00, 8'h01, 6'h02, 2, 6},  '{8'h03, 8'h02, 8'h03, 6'h03, 2, 14},
        '{8'h07, 8'h00, 8'h02, 6'h04, 2, 3},  '{8'h03, 8'h02, 8'h03, 6'h00, 2, 0},
        '{8'h11, 8'h00, 8'h01, 6'h00, 0, 0},  '{8'h21, 8'h00, 8'h01, 6'h00, 0, 0},
        '{8'h41, 8'h00, 8'h01, 6'h00, 0, 2}};

    pfdc_ctrl pfdc_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ref_tick(i_ref_tick),
        .o_fb_pulse(o_fb_pulse), .o_ref_pulse(o_ref_pulse), .o_status(o_status),
        .o_presc_code(o_presc_code));

    // ----------------------------------------------------------------
    // clock, reference ticks and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // one tick every third clock, launched just after the edge
    always @(posedge i_clk) begin
        ref_cnt <= (ref_cnt == 2) ? 0 : ref_cnt + 1;
        i_ref_tick <= #1 (ref_cnt == 2);
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        error_cnt++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // register port and measurement tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk) #1;
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = v;
        @(posedge i_clk) #1;
        i_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk) #1;
        i_addr = a;
        @(posedge i_clk);
        @(negedge i_clk) v = o_rdata;
    endtask : rd
    // counters held in reset while the divide values are loaded
    task automatic cfg(input pfdc_tb_per_s r);
        wr(8'h16, r.c | 8'h10);
        wr(8'h13, r.a);
        wr(8'h14, r.b);
        wr(8'h15, 8'h00);
        wr(8'h17, {r.s, 2'b00});
        wr(8'h16, r.c);
    endtask : cfg
    // kind 0 feedback pulse, 1 reference pulse, 2 status change; 0 if absent
    task automatic measure(input int k, output int p);
        int   t, e, last;
        logic prv, hit;
        p = 0;
        e = 0;
        last = 0;
        @(negedge i_clk) prv = o_status;
        for (t = 0; t < 200 && e < 3; t++) begin
            @(negedge i_clk);
            hit = (k == 0) ? o_fb_pulse : (k == 1) ? o_ref_pulse : (o_status !== prv);
            prv = o_status;
            if (hit === 1'b1) begin
                e++;
                if (e == 3) p = t - last;
                last = t;
            end
        end
    endtask : measure
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_rst = 1'b0;
        foreach (regs[i]) begin
            wr(regs[i].a, regs[i].w);
            rd(regs[i].a, d);
            `CHK("readback", regs[i].r, d)
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h16, 8'(c));
            @(negedge i_clk);
            `CHK("prescaler code", pfdc_presc_e'(c), o_presc_code)
        end
        $display("test prescaler codes done");
        wr(8'h11, 8'h02);
        wr(8'h12, 8'h00);
        foreach (per[i]) begin
            cfg(per[i]);
            measure(per[i].k, n);
            `CHK("period", per[i].p, n)
        end
        // reference side against the partial and full resets
        cfg(per[17]);
        measure(1, n);
        `CHK("ref period", 6, n)
        cfg(per[18]);
        measure(1, n);
        `CHK("ref held", 0, n)
        cfg(per[16]);
        measure(1, n);
        `CHK("ref held all", 0, n)
        $display("test divider periods done");
        // reset in mid-run clears registers and the pin
        cfg(per[11]);
        @(posedge i_clk) #1 i_rst = 1'b1;
        @(negedge i_clk);
        `CHK("status in reset", 1'b0, o_status)
        @(posedge i_clk) #1 i_rst = 1'b0;
        rd(8'h16, d);
        `CHK("ctrl after reset", 8'h00, d)
        rd(8'h17, d);
        `CHK("select after reset", 8'h00, d)
        measure(0, n);
        `CHK("period after reset", 1, n)
        $display("test reset done");
        end_of_test();
    end
endmodule : pfdc_ctrl_test
